// file: core/timer16_pkg.sv
// constants shared by the timer16 capture/compare block
package timer16_pkg;
  localparam logic [15:0] ADDR_MODE     = 16'hFF60;
  localparam logic [15:0] ADDR_PRESCALE = 16'hFF61;
  localparam logic [15:0] ADDR_CAPCTRL  = 16'hFF62;
  localparam logic [15:0] ADDR_OUTCTRL  = 16'hFF63;
  localparam logic [15:0] ADDR_PORT7DIR = 16'hFF27;
  localparam logic [15:0] ADDR_CC0_LO   = 16'hFF12;
  localparam logic [15:0] ADDR_CC0_HI   = 16'hFF13;
  localparam logic [15:0] ADDR_CC1_LO   = 16'hFF14;
  localparam logic [15:0] ADDR_CC1_HI   = 16'hFF15;
  localparam logic [15:0] ADDR_CNT_LO   = 16'hFF10;
  localparam logic [15:0] ADDR_CNT_HI   = 16'hFF11;
  localparam logic [15:0] ADDR_STATUS   = 16'hFF16;

  localparam logic [7:0] RST_MODE     = 8'h00;
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [7:0] RST_CAPCTRL  = 8'h00;
  localparam logic [7:0] RST_OUTCTRL  = 8'h00;
  localparam logic [7:0] RST_PORT7DIR = 8'hFF;

  // output control field positions
  localparam int OC_TOE   = 0;
  localparam int OC_INV0  = 1;
  localparam int OC_CLR   = 2;
  localparam int OC_SET   = 3;
  localparam int OC_INV1  = 4;
  localparam int OC_OSE   = 5;
  localparam int OC_OST   = 6;
  // capture control positions
  localparam int CC_CC0CAP = 0;
  localparam int CC_CC0INV = 1;
  localparam int CC_CC1CAP = 2;

  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [1:0] CLK_FX    = 2'h0;
  localparam logic [1:0] CLK_DIV4  = 2'h1;
  localparam logic [1:0] CLK_DIV64 = 2'h2;
  localparam logic [1:0] CLK_EDGE  = 2'h3;

  localparam logic [2:0] MODE_STOP  = 3'h0;
  localparam logic [2:0] MODE_FREE  = 3'h2;
  localparam logic [2:0] MODE_MATCH = 3'h6;

  // external-clock sampling rate fx/8
  localparam int EXT_SAMPLE_DIV = 8;
  localparam int PRESCALE_W     = 6;
endpackage

// file: core/edge_filter.sv
// two-sample noise filter and valid-edge detector for one timer input
`timescale 1ns/10ps
module edge_filter (
  input  wire logic       sys_clk,    // system clock
  input  wire logic       reset,      // sync reset, active high
  input  wire logic       pin_sync,   // input already synchronised
  input  wire logic       sample,     // sampling strobe
  input  wire logic       run,        // timer running
  input  wire logic [1:0] edge_sel,   // valid-edge selection
  output logic            rise,       // filtered rising edge
  output logic            fall,       // filtered falling edge
  output logic            valid_edge  // selected edge seen
);
  logic [1:0] hist_reg;
  logic       level_reg;
  logic       armed_reg;

  // R22: two equal samples
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hist_reg <= 2'h0;
    end else if (sample) begin
      hist_reg <= {hist_reg[0], pin_sync};
    end
  end

  // R14: level starts low so a high pin after reset gives one rise
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      level_reg <= 1'b0;
    end else if (sample && run && hist_reg[1] == hist_reg[0]) begin
      level_reg <= hist_reg[0];
    end else if (!run && armed_reg) begin
      level_reg <= hist_reg[0];
    end
  end

  // after the first run, a stop loads the last sampled level so an unchanged pin gives no edge on restart
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      armed_reg <= 1'b0;
    end else if (run) begin
      armed_reg <= 1'b1;
    end
  end

  always_comb begin
    rise = sample && run && hist_reg == 2'h3 && !level_reg;
    fall = sample && run && hist_reg == 2'h0 && level_reg;
    // R9: edge field decode
    // R10: same decode for pin 0
    case (edge_sel)
      timer16_pkg::EDGE_FALL: valid_edge = fall;
      timer16_pkg::EDGE_RISE: valid_edge = rise;
      timer16_pkg::EDGE_BOTH: valid_edge = rise || fall;
      default:                valid_edge = 1'b0;
    endcase
  end

  a_filter_two_samples: assert property (@(posedge sys_clk) disable iff (reset)
    rise |-> $past(hist_reg[0]) == 1'b1) // R22
    else $error("rise without two high samples");
endmodule

// file: core/count_prescaler.sv
// count clock selection: fx, fx/4, fx/64 or input edge
`timescale 1ns/10ps
module count_prescaler (
  input  wire logic       sys_clk,     // system clock
  input  wire logic       reset,       // sync reset, active high
  input  wire logic       run,         // timer running
  input  wire logic [1:0] clk_sel,     // count clock select
  input  wire logic       ext_edge,    // pin 0 valid edge
  output logic            count_tick,  // count enable strobe
  output logic            sample_tick  // edge sampling strobe
);
  logic [timer16_pkg::PRESCALE_W-1:0] div_reg;

  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // R11: count clock field
  always_comb begin
    case (clk_sel)
      timer16_pkg::CLK_FX:    count_tick = run;
      timer16_pkg::CLK_DIV4:  count_tick = run && div_reg[1:0] == 2'h3;
      timer16_pkg::CLK_DIV64: count_tick = run && &div_reg;
      default:                count_tick = ext_edge;
    endcase
  end

  // external clock sampled at fx/8, internal at the count clock
  always_comb begin
    if (clk_sel == timer16_pkg::CLK_EDGE) begin
      sample_tick = div_reg[2:0] == 3'(timer16_pkg::EXT_SAMPLE_DIV - 1);
    end else begin
      sample_tick = count_tick;
    end
  end
endmodule

// file: core/timer16_capture_compare.sv
// 16-bit timer with two capture/compare registers and output flip-flop
//
// Functional notes
// R1: trigger bit starts one-shot, reads zero
// R2: enable bit picks one-shot or continuous
// R3: match1 toggles output when enabled
// R4: match0 toggles output when enabled
// R5: set/clear field forces flip-flop, reads zero
// R6: output disabled forces pin low
// R7: software stops timer before output control
// R8: trigger only in one-shot mode
// R9: pin 1 edge field decode
// R10: pin 0 edge field decode
// R11: count clock field selects source
// R12: software stops timer before prescaler write
// R13: pin 0 clock excludes other pin uses
// R14: high pin after reset gives rise
// R15: port 7 direction, reset all ones
// R16: timer output needs direction and latch zero
// R17: interval mode clears on match0, irq
// R18: pulse period and width from compares
// R19: software keeps compare values ordered
// R20: pin 0 edge captures into compare 1
// R21: pin 1 edge captures into compare 0
// R22: edges sampled twice before capture
`timescale 1ns/10ps
module timer16_capture_compare (
  input  wire logic        sys_clk,      // 100 MHz system clock
  input  wire logic        reset,        // sync reset, active high
  input  wire logic [15:0] bus_addr,     // register address
  input  wire logic [7:0]  bus_wdata,    // write data
  input  wire logic        bus_write,    // write strobe
  input  wire logic        bus_read,     // read strobe
  output logic      [7:0]  bus_rdata,    // read data, cycle after strobe
  input  wire logic        input_pin_0,  // async input pin 0
  input  wire logic        input_pin_1,  // async input pin 1
  output logic             timer_output_pin, // timer output level
  output logic      [7:0]  port7_oe,     // port 7 driver enables
  output logic             match0_irq,   // match0 request pulse
  output logic             match1_irq    // match1 request pulse
);
  logic [7:0]  mode_reg, prescale_reg, capctrl_reg, outctrl_reg;
  logic [7:0]  port7_direction_reg;
  logic [15:0] main_counter, capture_compare_0, capture_compare_1;
  logic        out_ff_reg, overflow_reg;
  logic [1:0]  in0_meta, in1_meta;
  logic        cnt_tick, smp_tick, run;
  logic        r0, f0, e0, e1;
  logic        match0, match1, wr_out, trig;
  logic        shot_live_reg, tog_en;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      in0_meta <= 2'h0;
      in1_meta <= 2'h0;
    end else begin
      in0_meta <= {in0_meta[0], input_pin_0};
      in1_meta <= {in1_meta[0], input_pin_1};
    end
  end

  assign run = mode_reg[3:2] != 2'h0;

  edge_filter u_in0 (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .pin_sync   (in0_meta[1]),
    .sample     (smp_tick),
    .run        (run),
    .edge_sel   (prescale_reg[5:4]),
    .rise       (r0),
    .fall       (f0),
    .valid_edge (e0)
  );

  edge_filter u_in1 (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .pin_sync   (in1_meta[1]),
    .sample     (smp_tick),
    .run        (run),
    .edge_sel   (prescale_reg[7:6]),
    .rise       (),
    .fall       (),
    .valid_edge (e1)
  );

  count_prescaler u_pre (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .run         (run),
    .clk_sel     (prescale_reg[1:0]),
    .ext_edge    (e0),
    .count_tick  (cnt_tick),
    .sample_tick (smp_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // counter
  assign match0 = cnt_tick && main_counter == capture_compare_0;
  assign match1 = cnt_tick && main_counter == capture_compare_1;
  assign wr_out = bus_write && bus_addr == timer16_pkg::ADDR_OUTCTRL;
  // R1: write of one to trigger bit
  assign trig = wr_out && bus_wdata[timer16_pkg::OC_OST];
  assign tog_en = !outctrl_reg[timer16_pkg::OC_OSE] || shot_live_reg;

  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      main_counter <= 16'h0000;
    end else if (trig && outctrl_reg[timer16_pkg::OC_OSE]) begin
      // one-shot restarts the free-running count
      main_counter <= 16'h0000;
    end else if (cnt_tick) begin
      // R17: clear and keep counting on match0
      // R18: period is compare0 plus one
      if (mode_reg[3:1] == timer16_pkg::MODE_MATCH && match0) begin
        main_counter <= 16'h0000;
      end else begin
        main_counter <= main_counter + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      overflow_reg <= 1'b0;
    end else if (cnt_tick && main_counter == 16'hFFFF) begin
      overflow_reg <= 1'b1;
    end else if (bus_write && bus_addr == timer16_pkg::ADDR_MODE &&
                 !bus_wdata[0]) begin
      overflow_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture/compare registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      capture_compare_0 <= 16'h0000;
    end else if (capctrl_reg[timer16_pkg::CC_CC0CAP] &&
                 (capctrl_reg[timer16_pkg::CC_CC0INV] ?
                  (prescale_reg[5:4] == timer16_pkg::EDGE_FALL ? r0 :
                   prescale_reg[5:4] == timer16_pkg::EDGE_RISE ? f0 : 1'b0)
                  : e1)) begin
      // R21: pin 1 edge copies count into compare 0; with CC0INV set, the pin 0 edge opposite to a rise or fall selection does
      capture_compare_0 <= main_counter;
    end else if (bus_write && bus_addr == timer16_pkg::ADDR_CC0_LO) begin
      capture_compare_0[7:0] <= bus_wdata;
    end else if (bus_write && bus_addr == timer16_pkg::ADDR_CC0_HI) begin
      capture_compare_0[15:8] <= bus_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      capture_compare_1 <= 16'h0000;
    end else if (capctrl_reg[timer16_pkg::CC_CC1CAP] && e0) begin
      // R20: pin 0 edge copies count into compare 1
      capture_compare_1 <= main_counter;
    end else if (bus_write && bus_addr == timer16_pkg::ADDR_CC1_LO) begin
      capture_compare_1[7:0] <= bus_wdata;
    end else if (bus_write && bus_addr == timer16_pkg::ADDR_CC1_HI) begin
      capture_compare_1[15:8] <= bus_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      match0_irq <= 1'b0;
      match1_irq <= 1'b0;
    end else begin
      // R17: match0 raises request
      match0_irq <= (!capctrl_reg[timer16_pkg::CC_CC0CAP] && match0) ||
                    (capctrl_reg[timer16_pkg::CC_CC0CAP] && e1);
      // R20: capture on pin 0 raises match1 request
      match1_irq <= (!capctrl_reg[timer16_pkg::CC_CC1CAP] && match1) ||
                    (capctrl_reg[timer16_pkg::CC_CC1CAP] && e0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers; writes assume the timer is stopped
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_reg            <= timer16_pkg::RST_MODE;
      prescale_reg        <= timer16_pkg::RST_PRESCALE;
      capctrl_reg         <= timer16_pkg::RST_CAPCTRL;
      port7_direction_reg <= timer16_pkg::RST_PORT7DIR;
    end else if (bus_write) begin
      if (bus_addr == timer16_pkg::ADDR_MODE) begin
        mode_reg <= {4'h0, bus_wdata[3:1], 1'b0};
      end else if (bus_addr == timer16_pkg::ADDR_PRESCALE) begin
        // R12: software keeps timer stopped here
        prescale_reg <= {bus_wdata[7:4], 2'h0, bus_wdata[1:0]};
      end else if (bus_addr == timer16_pkg::ADDR_CAPCTRL) begin
        capctrl_reg <= {5'h00, bus_wdata[2:0]};
      end else if (bus_addr == timer16_pkg::ADDR_PORT7DIR) begin
        // R15: top two bits fixed at one
        port7_direction_reg <= {2'h3, bus_wdata[5:0]};
      end
    end
  end

  // R5: set/clear and trigger bits are not stored
  // R7: software stops timer before writing here
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      outctrl_reg <= timer16_pkg::RST_OUTCTRL;
    end else if (wr_out) begin
      outctrl_reg <= {2'h0, bus_wdata[5:4], 2'h0, bus_wdata[1:0]};
    end
  end

  // R2: one-shot toggles only from trigger to match0
  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      shot_live_reg <= 1'b0;
    end else if (trig && outctrl_reg[timer16_pkg::OC_OSE]) begin
      shot_live_reg <= 1'b1;
    end else if (match0) begin
      shot_live_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output flip-flop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_ff_reg <= 1'b0;
    end else if (wr_out && bus_wdata[3:2] == 2'h1) begin
      // R5: clear
      out_ff_reg <= 1'b0;
    end else if (wr_out && bus_wdata[3:2] == 2'h2) begin
      // R5: set
      out_ff_reg <= 1'b1;
    end else if (run && tog_en) begin
      // R2: one-shot gates toggles to after trigger
      // R3: toggle on match1
      // R4: toggle on match0
      out_ff_reg <= out_ff_reg ^
        (match0 && outctrl_reg[timer16_pkg::OC_INV0]) ^
        (match1 && outctrl_reg[timer16_pkg::OC_INV1]);
    end
  end

  // R6: disabled output reads low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_pin <= outctrl_reg[timer16_pkg::OC_TOE] & out_ff_reg;
    end
  end

  // R15: zero means driver on
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      port7_oe <= 8'h00;
    end else begin
      port7_oe <= ~port7_direction_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_rdata <= 8'h00;
    end else if (bus_read) begin
      if (bus_addr == timer16_pkg::ADDR_MODE) begin
        bus_rdata <= {mode_reg[7:1], overflow_reg};
      end else if (bus_addr == timer16_pkg::ADDR_PRESCALE) begin
        bus_rdata <= prescale_reg;
      end else if (bus_addr == timer16_pkg::ADDR_CAPCTRL) begin
        bus_rdata <= capctrl_reg;
      end else if (bus_addr == timer16_pkg::ADDR_OUTCTRL) begin
        // R1: trigger reads zero
        bus_rdata <= outctrl_reg;
      end else if (bus_addr == timer16_pkg::ADDR_PORT7DIR) begin
        bus_rdata <= port7_direction_reg;
      end else if (bus_addr == timer16_pkg::ADDR_CC0_LO) begin
        bus_rdata <= capture_compare_0[7:0];
      end else if (bus_addr == timer16_pkg::ADDR_CC0_HI) begin
        bus_rdata <= capture_compare_0[15:8];
      end else if (bus_addr == timer16_pkg::ADDR_CC1_LO) begin
        bus_rdata <= capture_compare_1[7:0];
      end else if (bus_addr == timer16_pkg::ADDR_CC1_HI) begin
        bus_rdata <= capture_compare_1[15:8];
      end else if (bus_addr == timer16_pkg::ADDR_CNT_LO) begin
        bus_rdata <= main_counter[7:0];
      end else if (bus_addr == timer16_pkg::ADDR_CNT_HI) begin
        bus_rdata <= main_counter[15:8];
      end else if (bus_addr == timer16_pkg::ADDR_STATUS) begin
        bus_rdata <= {6'h00, in1_meta[1], out_ff_reg};
      end else begin
        bus_rdata <= 8'h00;
      end
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_clear_write;
    wr_out && bus_wdata[3:2] == 2'h1;
  endsequence

  a_oc_readback: assert property (@(posedge sys_clk) disable iff (reset)
    outctrl_reg[6] == 1'b0 && outctrl_reg[3:2] == 2'h0) // R1
    else $error("self-clearing bits stored");
  a_ff_clear: assert property (@(posedge sys_clk) disable iff (reset)
    s_clear_write |=> !out_ff_reg) // R5
    else $error("clear write did not clear flip-flop");
  a_ff_set: assert property (@(posedge sys_clk) disable iff (reset)
    wr_out && bus_wdata[3:2] == 2'h2 |=> out_ff_reg) // R5
    else $error("set write did not set flip-flop");
  a_toggle_m0: assert property (@(posedge sys_clk) disable iff (reset)
    run && tog_en && !wr_out && match0 && outctrl_reg[1] &&
    !(match1 && outctrl_reg[4])
    |=> out_ff_reg != $past(out_ff_reg)) // R4
    else $error("match0 did not toggle");
  a_toggle_m1: assert property (@(posedge sys_clk) disable iff (reset)
    run && tog_en && !wr_out && match1 && outctrl_reg[4] &&
    !(match0 && outctrl_reg[1])
    |=> out_ff_reg != $past(out_ff_reg)) // R3
    else $error("match1 did not toggle");
  a_out_disabled: assert property (@(posedge sys_clk) disable iff (reset)
    !outctrl_reg[0] |=> !timer_output_pin) // R6
    else $error("disabled output not low");
  a_interval_clr: assert property (@(posedge sys_clk) disable iff (reset)
    mode_reg[3:1] == 3'h6 && match0 && !trig |=> main_counter == 16'h0000
    ##0 match0_irq) // R17
    else $error("interval clear or request missing");
  a_cap_cc1: assert property (@(posedge sys_clk) disable iff (reset)
    capctrl_reg[2] && e0 |=> capture_compare_1 == $past(main_counter)
    && match1_irq) // R20
    else $error("capture into compare 1 failed");
  a_port_dir: assert property (@(posedge sys_clk) disable iff (reset)
    ##1 port7_oe == ~$past(port7_direction_reg)) // R15
    else $error("port driver enable mismatch");
endmodule

// file: tb/pulse_source.sv
// external pulse sources on the two timer inputs and the output load
`timescale 1ns/10ps
module pulse_source (
  input  wire logic sys_clk,          // system clock
  input  wire logic timer_output_pin, // timer output load
  output logic      input_pin_0,      // pulse source 0
  output logic      input_pin_1       // pulse source 1
);
  initial begin
    input_pin_0 = 1'b0;
    input_pin_1 = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // held whole cycles
  // levels move just after an edge; a zero hold is a one-cycle glitch in t_capture and leaves the pins high in t_power
  task automatic drive(input logic l0, input logic l1, input int cycles);
    @(posedge sys_clk);
    input_pin_0 <= l0;
    input_pin_1 <= l1;
    repeat (cycles) @(posedge sys_clk);
  endtask
endmodule

// file: tb/timer16_capture_compare_bench.sv
// self-checking bench for the timer16 capture/compare block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
  checks_done++; \
  if ((got) !== (ex)) begin \
    mismatches++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
  end \
end
module timer16_capture_compare_bench;
  logic        sys_clk     = 1'b0;
  logic        reset       = 1'b1;
  logic [15:0] bus_addr    = 16'h0000;
  logic [7:0]  bus_wdata   = 8'h00;
  logic        bus_write   = 1'b0;
  logic        bus_read    = 1'b0;
  logic [7:0]  bus_rdata;
  logic        input_pin_0;
  logic        input_pin_1;
  logic        timer_output_pin;
  logic [7:0]  port7_oe;
  logic        match0_irq;
  logic        match1_irq;
  int          mismatches  = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  int          n0          = 0;
  int          n1          = 0;

  timer16_capture_compare i_timer16_capture_compare (
    .sys_clk          (sys_clk),
    .reset            (reset),
    .bus_addr         (bus_addr),
    .bus_wdata        (bus_wdata),
    .bus_write        (bus_write),
    .bus_read         (bus_read),
    .bus_rdata        (bus_rdata),
    .input_pin_0      (input_pin_0),
    .input_pin_1      (input_pin_1),
    .timer_output_pin (timer_output_pin),
    .port7_oe         (port7_oe),
    .match0_irq       (match0_irq),
    .match1_irq       (match1_irq)
  );
  pulse_source i_pulse_source (
    .sys_clk          (sys_clk),
    .timer_output_pin (timer_output_pin),
    .input_pin_0      (input_pin_0),
    .input_pin_1      (input_pin_1)
  );

  always #5 sys_clk = ~sys_clk;

  // irq pulses last one cycle, so they are counted here rather than polled
  always @(posedge sys_clk) begin
    cycles++;
    if (match0_irq === 1'b1) n0++;
    if (match1_irq === 1'b1) n1++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge sys_clk);
    bus_write <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge sys_clk);
    bus_read <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic rd16(input logic [15:0] a, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 16'h0001, hi);
    v = {hi, lo};
  endtask
  task automatic wr16(input logic [15:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 16'h0001, v[15:8]);
  endtask
  task automatic chk_rd(input logic [15:0] a, input logic [7:0] ex,
                        input string nm);
    logic [7:0] d;
    rd(a, d);
    `CHK(nm, ex, d)
  endtask
  task automatic set_mode(input logic [2:0] m);
    wr(timer16_pkg::ADDR_MODE, {4'h0, m, 1'b0});
  endtask
  function automatic logic probe(input int sel);
    case (sel)
      0: return match0_irq;
      1: return match1_irq;
      default: return timer_output_pin;
    endcase
  endfunction
  task automatic wait_for(input int sel, input logic lvl, input int lim,
                          output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (probe(sel) !== lvl && n < lim);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    chk_rd(timer16_pkg::ADDR_PRESCALE, 8'h00, "prescale");
    chk_rd(timer16_pkg::ADDR_OUTCTRL, 8'h00, "outctrl");
    chk_rd(timer16_pkg::ADDR_PORT7DIR, 8'hFF, "dir");
    `CHK("oe rst", 8'h00, port7_oe)
    wr(timer16_pkg::ADDR_PORT7DIR, 8'h3E);
    chk_rd(timer16_pkg::ADDR_PORT7DIR, 8'hFE, "dir wr");
    `CHK("oe", 8'h01, port7_oe)
    wr(timer16_pkg::ADDR_PRESCALE, 8'hF1);
    chk_rd(timer16_pkg::ADDR_PRESCALE, 8'hF1, "presc");
    chk_rd(16'hFF00, 8'h00, "unmapped");
  endtask
  task automatic t_outff();
    logic [7:0] v[4] = '{8'h09, 8'h00, 8'h01, 8'h05};
    logic       p[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    for (int k = 0; k < 4; k++) begin
      wr(timer16_pkg::ADDR_OUTCTRL, v[k]);
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("out pin", p[k], timer_output_pin)
    end
    chk_rd(timer16_pkg::ADDR_OUTCTRL, 8'h01, "ff rd0");
  endtask
  task automatic t_interval();
    int   div[3] = '{1, 4, 64};
    int   n;
    logic p;
    wr16(timer16_pkg::ADDR_CC0_LO, 16'h0004);
    for (int s = 0; s < 3; s++) begin
      set_mode(timer16_pkg::MODE_STOP);
      wr(timer16_pkg::ADDR_PRESCALE, {6'h00, s[1:0]});
      wr(timer16_pkg::ADDR_OUTCTRL, 8'h03);
      set_mode(timer16_pkg::MODE_MATCH);
      wait_for(0, 1'b1, 1000, n);
      repeat (3) @(posedge sys_clk);
      #1 p = timer_output_pin;
      wait_for(0, 1'b1, 1000, n);
      `CHK("interval", 5 * div[s], n + 3)
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("toggle", ~p, timer_output_pin)
    end
  endtask
  task automatic t_extclk();
    logic [15:0] v;
    set_mode(timer16_pkg::MODE_STOP);
    wr(timer16_pkg::ADDR_OUTCTRL, 8'h00);
    wr(timer16_pkg::ADDR_CAPCTRL, 8'h00);
    wr(timer16_pkg::ADDR_PRESCALE, 8'h13);
    set_mode(timer16_pkg::MODE_FREE);
    repeat (3) begin
      i_pulse_source.drive(1'b1, 1'b0, 32);
      i_pulse_source.drive(1'b0, 1'b0, 32);
    end
    rd16(timer16_pkg::ADDR_CNT_LO, v);
    `CHK("edge count", 16'h0003, v)
  endtask
  task automatic t_pulse();
    int n;
    int hi;
    int lo;
    set_mode(timer16_pkg::MODE_STOP);
    wr(timer16_pkg::ADDR_PRESCALE, 8'h00);
    wr16(timer16_pkg::ADDR_CC0_LO, 16'h0009);
    wr16(timer16_pkg::ADDR_CC1_LO, 16'h0003);
    wr(timer16_pkg::ADDR_OUTCTRL, 8'h17);
    set_mode(timer16_pkg::MODE_MATCH);
    wait_for(2, 1'b1, 100, n);
    wait_for(2, 1'b0, 100, hi);
    wait_for(2, 1'b1, 100, lo);
    `CHK("period", 10, hi + lo)
    `CHK("width", 4, (hi < lo) ? hi : lo)
    set_mode(timer16_pkg::MODE_STOP);
    // match1 falls inside the wait below, match0 beyond it
    wr16(timer16_pkg::ADDR_CC0_LO, 16'h001E);
    wr16(timer16_pkg::ADDR_CC1_LO, 16'h0014);
    wr(timer16_pkg::ADDR_OUTCTRL, 8'h37);
    set_mode(timer16_pkg::MODE_FREE);
    // an untriggered match1 must leave the pin low
    repeat (25) @(posedge sys_clk);
    #1;
    `CHK("early shot", 1'b0, timer_output_pin)
    wr(timer16_pkg::ADDR_OUTCTRL, 8'h73);
    chk_rd(timer16_pkg::ADDR_OUTCTRL, 8'h33, "trig rd");
    wait_for(2, 1'b1, 60, n);
    `CHK("shot start", 1'b1, n < 60)
    wait_for(2, 1'b0, 60, hi);
    `CHK("shot width", 10, hi)
  endtask
  task automatic t_capture();
    logic [1:0]  codes[3] = '{timer16_pkg::EDGE_FALL,
                              timer16_pkg::EDGE_RISE,
                              timer16_pkg::EDGE_BOTH};
    logic [15:0] cb;
    logic [15:0] c0;
    logic [15:0] c1;
    logic [15:0] ca;
    int          e;
    for (int k = 0; k < 3; k++) begin
      set_mode(timer16_pkg::MODE_STOP);
      wr(timer16_pkg::ADDR_PRESCALE, {codes[k], codes[k], 4'h0});
      wr(timer16_pkg::ADDR_CAPCTRL, 8'h05);
      set_mode(timer16_pkg::MODE_FREE);
      #1 n0 = 0;
      n1 = 0;
      rd16(timer16_pkg::ADDR_CNT_LO, cb);
      i_pulse_source.drive(1'b1, 1'b1, 20);
      e = int'(codes[k] != timer16_pkg::EDGE_FALL);
      `CHK("rise 0", e, n0)
      `CHK("rise 1", e, n1)
      if (e == 1) begin
        rd16(timer16_pkg::ADDR_CC0_LO, c0);
        rd16(timer16_pkg::ADDR_CC1_LO, c1);
        rd16(timer16_pkg::ADDR_CNT_LO, ca);
        `CHK("cap time", 1'b1, c1 > cb && c1 < ca)
        `CHK("cap pair", c1, c0)
      end
      i_pulse_source.drive(1'b0, 1'b0, 20);
      e = e + int'(codes[k] != timer16_pkg::EDGE_RISE);
      `CHK("fall 0", e, n0)
      `CHK("fall 1", e, n1)
    end
    i_pulse_source.drive(1'b1, 1'b0, 0);
    i_pulse_source.drive(1'b0, 1'b0, 20);
    `CHK("glitch", e, n1)
  endtask
  task automatic t_power();
    i_pulse_source.drive(1'b1, 1'b1, 0);
    do_reset();
    wr(timer16_pkg::ADDR_PRESCALE, 8'h50);
    wr(timer16_pkg::ADDR_CAPCTRL, 8'h05);
    #1 n0 = 0;
    n1 = 0;
    set_mode(timer16_pkg::MODE_FREE);
    repeat (20) @(posedge sys_clk);
    `CHK("first run", 2, n0 + n1)
    set_mode(timer16_pkg::MODE_STOP);
    set_mode(timer16_pkg::MODE_FREE);
    repeat (20) @(posedge sys_clk);
    `CHK("rerun", 2, n0 + n1)
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    t_regs();
    t_outff();
    t_interval();
    t_extclk();
    t_pulse();
    t_capture();
    t_power();
    end_sim();
  end
endmodule
